/* irq_unit.sv */
/*
  Request-flag unit: two sticky request registers, two enable registers,
  global request, interrupt pin drive, command field with idle return.
  Assumes event inputs are one-cycle pulses or levels synchronous to mclk.
*/
// The address-and-strobe port was chosen for this implementation.
module irq_unit
  import irq_pkg::*;
#(
  parameter int NTIMER = 5
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  // FIFO state
  input wire logic [9:0] fifo_fill_count,
  // Event inputs
  input wire logic cmd_finished,
  input wire logic tx_last_bit,
  input wire logic rx_stream_end,
  input wire logic rx_sof_seen,
  input wire logic card_found,
  input wire logic [NTIMER-1:0] tmr_underflow,
  // Error sources
  input wire logic fifo_write_misuse_err,
  input wire logic fifo_overflow_err,
  input wire logic protocol_err,
  input wire logic empty_send_err,
  input wire logic integrity_err,
  // Command field out to the sequencer
  output logic [7:0] command_q,
  // Interrupt pin
  output logic irq_pin_o_q,
  output logic irq_pin_oe_q
);

  // Elaboration check: the timer field is
  // fixed at five underflow flags
  if (NTIMER != 5)
  begin : g_ntimer_check
    $error("irq_unit: NTIMER must be 5");
  end

  // Sticky flags, set by hardware or host, cleared by host
  // Flag registers and configuration
  logic [6:0] status_a_q; // High..frame-start flags
  logic [5:0] status_b_q; // Card and timer flags
  logic global_request_flag; // Combinational OR
  logic global_q; // Registered global flag
  logic [7:0] enable_a_q; // Invert plus enables
  logic [7:0] enable_b_q; // Drive, gate, enables
  logic fifo_capacity_select_q; // 1: 255 bytes
  logic [8:0] water_q; // Watermark level
  logic [4:0] error_q; // Error lines delayed one cycle
  logic pend_check_q; // Command start awaiting check
  logic known; // Lookup result

  ////////////////////////////////////////////////////////////////////////
  // Strobes
  // Write strobes decoded per target register
  logic wr_a, wr_b, wr_cmd;
  assign wr_a = wr && (addr == ADDR_STATUS_A);
  assign wr_b = wr && (addr == ADDR_STATUS_B);
  assign wr_cmd = wr && (addr == ADDR_COMMAND);

  ////////////////////////////////////////////////////////////////////////
  // Watermark alerts
  logic [9:0] capacity;
  logic [9:0] level;
  logic fifo_high_mark_live, fifo_low_mark_live;
  logic high_prev_q, low_prev_q;
  // Live alerts from fill level against the mark
  always_comb
  begin
    // Capacity from size select
    capacity = fifo_capacity_select_q ? CAP_SMALL : CAP_LARGE;
    // Extension bit only counts in large mode
    level = fifo_capacity_select_q ? {2'b00, water_q[7:0]}
                                   : {1'b0, water_q};
    // Guard keeps the subtraction from wrapping
    fifo_high_mark_live = (fifo_fill_count <= capacity) &&
      ((capacity - fifo_fill_count) <= level);
    fifo_low_mark_live = (fifo_fill_count <= level);
  end

  // Previous live alerts for rising-edge detection
  // Reset to zero so a level already true latches once
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_prev_q <= 1'b0;
      low_prev_q <= 1'b0;
    end
    else
    begin
      high_prev_q <= fifo_high_mark_live;
      low_prev_q <= fifo_low_mark_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command lookup
  // Lookup registered so its answer lines up with
  // the pending check one cycle after the start
  cmd_table #(.NCMD(NUM_CMDS)) u_cmd_table (
    .mclk(mclk),
    .resetn(resetn),
    .code(wdata),
    .known_q(known)
  );

  // Unknown command: one cycle after start the lookup answers
  logic unknown_cmd;
  assign unknown_cmd = pend_check_q && !known && !wr_cmd;

  // Command field and its pending check
  // A finished or refused command returns to idle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      command_q <= CMD_IDLE;
      pend_check_q <= 1'b0;
    end
    else if (wr_cmd)
    begin
      // Host start; idle write never arms the check
      command_q <= wdata;
      pend_check_q <= (wdata != CMD_IDLE);
    end
    else
    begin
      // No host write: check lasts one cycle only
      pend_check_q <= 1'b0;
      if (unknown_cmd || cmd_finished)
        command_q <= CMD_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flags, edge detection for the error request
  logic [4:0] err_live;
  assign err_live = {fifo_write_misuse_err, fifo_overflow_err,
                     protocol_err, empty_send_err, integrity_err};
  // Only a rising error line raises the request,
  // so a stuck error does not refire after a clear
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      error_q <= 5'h00;
    else
      error_q <= err_live;
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware set vectors
  logic [6:0] set_a;
  logic [5:0] set_b;
  // One-cycle set pulses, merged below with host writes
  always_comb
  begin
    set_a = 7'h00;
    set_a[HIGH_BIT] = fifo_high_mark_live && !high_prev_q;
    set_a[LOW_BIT] = fifo_low_mark_live && !low_prev_q;
    // Self end or unknown code; host idle write excluded
    set_a[CMD_DONE_BIT] = (cmd_finished && command_q != CMD_IDLE
                           && !wr_cmd) || unknown_cmd;
    set_a[TX_DONE_BIT] = tx_last_bit;
    set_a[RX_DONE_BIT] = rx_stream_end;
    set_a[ERR_BIT] = |(err_live & ~error_q);
    set_a[SOF_BIT] = rx_sof_seen;
    set_b = {card_found, tmr_underflow};
  end

  ////////////////////////////////////////////////////////////////////////
  // Request register A
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      status_a_q <= STATUS_A_RST[6:0];
    // Set mode: ones written join the flags
    else if (wr_a && wdata[SET_MODE_BIT])
      status_a_q <= status_a_q | wdata[6:0] | set_a;
    else if (wr_a)
      // Clear ones written, hardware set wins
      status_a_q <= (status_a_q & ~wdata[6:0]) | set_a;
    // No write: only hardware sets
    else
      status_a_q <= status_a_q | set_a;
  end

  // Request register B, bit seven is write-only
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      status_b_q <= STATUS_B_RST;
    // Set mode: ones written join the flags
    else if (wr_b && wdata[SET_MODE_BIT])
      status_b_q <= status_b_q | wdata[5:0] | set_b;
    else if (wr_b)
      status_b_q <= (status_b_q & ~wdata[5:0]) | set_b;
    // No write: only hardware sets
    else
      status_b_q <= status_b_q | set_b;
  end

  ////////////////////////////////////////////////////////////////////////
  // Global request, recomputed every clock
  always_comb
  begin
    global_request_flag = |(status_a_q & enable_a_q[6:0])
                        | |(status_b_q & enable_b_q[5:0]);
  end

  // Registered copy for the read-back of bit six
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      global_q <= 1'b0;
    else
      global_q <= global_request_flag;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  // Host-written configuration, unmapped offsets ignored
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      enable_a_q <= ENABLE_RST;
      enable_b_q <= ENABLE_RST;
      fifo_capacity_select_q <= 1'b0;
      water_q <= WATER_RST;
    end
    else if (wr)
    begin
      unique case (addr)
        ADDR_ENABLE_A: enable_a_q <= wdata;
        ADDR_ENABLE_B: enable_b_q <= wdata;
        ADDR_FIFO_CFG:
        begin
          fifo_capacity_select_q <= wdata[CAPACITY_BIT];
          water_q[8] <= wdata[WATER_EXT_BIT];
        end
        ADDR_WATER: water_q[7:0] <= wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin drive
  logic pin_level;
  logic pin_active;
  // Inversion applies after the gate, so a gated-off
  // pin rests at the inverted idle level
  always_comb
  begin
    // Gated request, then optional inversion
    pin_active = global_request_flag && enable_b_q[PIN_GATE_BIT];
    pin_level = pin_active ^ enable_a_q[INVERT_BIT];
  end

  // Registered pin drive; enable high while driving
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_pin_o_q <= 1'b0;
      irq_pin_oe_q <= 1'b0;
    end
    else if (enable_b_q[DRIVE_SEL_BIT])
    begin
      // Push-pull: always driven
      irq_pin_o_q <= pin_level;
      irq_pin_oe_q <= 1'b1;
    end
    else
    begin
      // Open drain: pull low only when level is low
      irq_pin_o_q <= 1'b0;
      irq_pin_oe_q <= !pin_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  // Unmapped offsets and idle cycles read as zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else if (rd)
    begin
      unique case (addr)
        ADDR_STATUS_A: rdata_q <= {1'b0, status_a_q};
        ADDR_STATUS_B: rdata_q <= {1'b0, global_q, status_b_q};
        ADDR_ENABLE_A: rdata_q <= enable_a_q;
        ADDR_ENABLE_B: rdata_q <= enable_b_q;
        ADDR_FIFO_CFG:
          // Delayed live alerts in bits six and five
          rdata_q <= {fifo_capacity_select_q, high_prev_q, low_prev_q,
                      2'b00, water_q[8], 2'b00};
        ADDR_WATER: rdata_q <= water_q[7:0];
        ADDR_COMMAND: rdata_q <= command_q;
        ADDR_ERROR: rdata_q <= {3'b000, error_q};
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

endmodule : irq_unit

/* irq_pkg.sv */
/*
  Shared constants of the request-flag unit: register offsets, field
  positions, reset values and command codes.
  Assumes an 8-bit register port and a single clock domain.
*/
package irq_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS_A = 8'h06;
  localparam logic [7:0] ADDR_STATUS_B = 8'h07;
  localparam logic [7:0] ADDR_ENABLE_A = 8'h08;
  localparam logic [7:0] ADDR_ENABLE_B = 8'h09;
  localparam logic [7:0] ADDR_FIFO_CFG = 8'h02;
  localparam logic [7:0] ADDR_WATER = 8'h03;
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_ERROR = 8'h0A;

  // Field positions
  localparam int SET_MODE_BIT = 7;
  localparam int GLOBAL_BIT = 6;
  localparam int INVERT_BIT = 7;
  localparam int DRIVE_SEL_BIT = 7;
  localparam int PIN_GATE_BIT = 6;
  localparam int HIGH_BIT = 6;
  localparam int LOW_BIT = 5;
  localparam int CMD_DONE_BIT = 4;
  localparam int TX_DONE_BIT = 3;
  localparam int RX_DONE_BIT = 2;
  localparam int ERR_BIT = 1;
  localparam int SOF_BIT = 0;
  localparam int CARD_BIT = 5;
  localparam int CAPACITY_BIT = 7;
  localparam int WATER_EXT_BIT = 2;

  // Reset values
  localparam logic [7:0] STATUS_A_RST = 8'h00;
  localparam logic [5:0] STATUS_B_RST = 6'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [8:0] WATER_RST = 9'h000;

  // FIFO capacities in bytes
  localparam logic [9:0] CAP_SMALL = 10'h0FF;
  localparam logic [9:0] CAP_LARGE = 10'h200;

  // Command codes
  localparam logic [7:0] CMD_IDLE = 8'h00;
  localparam int NUM_CMDS = 8;

endpackage : irq_pkg

/* cmd_table.sv */
/*
  Table of known command codes, registered lookup.
  Assumes the command code is presented one cycle before use.
*/
module cmd_table
  import irq_pkg::*;
#(
  parameter int NCMD = NUM_CMDS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Lookup
  input wire logic [7:0] code,
  output logic known_q
);

  // Elaboration check: codes are eight bits wide
  if (NCMD < 1 || NCMD > 256)
  begin : g_ncmd_check
    $error("cmd_table: NCMD out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered check: codes below NCMD are implemented
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      known_q <= 1'b0;
    else
      known_q <= ({24'h0000_00, code} < 32'(NCMD));
  end

endmodule : cmd_table

/* irq_unit_properties.sv */
/* Port checker for the request-flag unit.
   Assumes a bind to irq_unit; one clock, async active-low reset. */
module irq_unit_check
  import irq_pkg::*;
(
  // Clock, reset, bus
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata_q,
  // Events, command, pin
  input wire logic cmd_finished,
  input wire logic tx_last_bit,
  input wire logic rx_stream_end,
  input wire logic card_found,
  input wire logic [7:0] command_q,
  input wire logic irq_pin_o_q,
  input wire logic irq_pin_oe_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Set-all writes read back at once
  set_all_a: assert property (
    wr && addr == ADDR_STATUS_A && wdata == 8'hFF ##1 rd &&
    addr == ADDR_STATUS_A |=> rdata_q == 8'h7F) else $error("set A");
  set_all_b_a: assert property (
    wr && addr == ADDR_STATUS_B && wdata == 8'hFF ##1 rd &&
    addr == ADDR_STATUS_B |=> rdata_q[7] == 1'b0 && rdata_q[5:0] == 6'h3F)
    else $error("set B");
  // Event flags seen on the next read
  tx_flag_a: assert property (
    tx_last_bit ##1 rd && addr == ADDR_STATUS_A |=> rdata_q[TX_DONE_BIT])
    else $error("tx flag");
  rx_flag_a: assert property (
    rx_stream_end ##1 rd && addr == ADDR_STATUS_A |=> rdata_q[RX_DONE_BIT])
    else $error("rx flag");
  card_flag_a: assert property (
    card_found ##1 (!wr)[*2] ##1 rd && addr == ADDR_STATUS_B |=>
    rdata_q[CARD_BIT]) else $error("card flag");
  // Command field goes back to idle
  unknown_cmd_a: assert property (
    command_q >= 8'(NUM_CMDS) && !wr |=> command_q == CMD_IDLE)
    else $error("unknown command held");
  cmd_end_a: assert property (
    cmd_finished && !wr |=> command_q == CMD_IDLE) else $error("cmd end");
  // Pin high only while driven
  pin_drive_a: assert property (
    irq_pin_o_q |-> irq_pin_oe_q) else $error("pin high undriven");
endmodule : irq_unit_check

/* host_model.sv */
/* Host controller model: register writes and reads.
   Assumes its tasks are called just after a rising edge of mclk. */
module host_model
(
  // Clock and read data
  input wire logic mclk,
  input wire logic [7:0] rdata_q,
  // Register port
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {addr, wdata, wr, rd} = '0;
  end
  // Write, strobe left up so writes can follow back to back
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
  endtask : wreg
  // Read; lines released inverted, data taken mid-cycle while it stands
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~wdata;
    @(negedge mclk);
    d = rdata_q;
    @(posedge mclk);
  endtask : rreg
  // Strobes down for n cycles
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle
endmodule : host_model

/* tb_irq_unit.sv */
/* Bench for irq_unit: integer flag model checked at every read.
   Assumes irq_pkg, host_model and the checker are compiled first. */
module tb_irq_unit
  import irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic fin = 1'b0;
  logic [9:0] fill = 10'h000;
  logic [13:0] ev = 14'h0000;
  logic [7:0] addr, wdata, rdata_q, command_q, got;
  logic wr, rd, pin_o, pin_oe, v;
  int sa, sb, ena, enb, n_mismatch, check_count, cyc;
  always #5 mclk = ~mclk;
  host_model i_host (.mclk, .rdata_q, .addr, .wdata, .wr, .rd);
  irq_unit i_irq_unit (.mclk, .resetn, .addr, .wdata, .wr, .rd, .rdata_q,
    .fifo_fill_count(fill), .cmd_finished(fin), .tx_last_bit(ev[0]),
    .rx_stream_end(ev[1]), .rx_sof_seen(ev[2]), .card_found(ev[3]),
    .tmr_underflow(ev[8:4]), .fifo_write_misuse_err(ev[9]),
    .fifo_overflow_err(ev[10]), .protocol_err(ev[11]),
    .empty_send_err(ev[12]), .integrity_err(ev[13]), .command_q,
    .irq_pin_o_q(pin_o), .irq_pin_oe_q(pin_oe));
  ////////////////////////////////////////////////////////////
  // Model of the global request
  function automatic logic glob();
    return ((sa & ena & 8'h7F) != 0) || ((sb & enb & 8'h3F) != 0);
  endfunction : glob
  // Model read value per address
  function automatic logic [7:0] exp_of(input logic [7:0] a);
    case (a)
      ADDR_STATUS_A: return 8'(sa & 8'h7F);
      ADDR_STATUS_B: return {1'b0, glob(), 6'(sb)};
      ADDR_ENABLE_A: return 8'(ena);
      ADDR_ENABLE_B: return 8'(enb);
      default: return 8'h00;
    endcase
  endfunction : exp_of
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a);
    i_host.rreg(a, got);
    chk($sformatf("reg %h", a), exp_of(a), got);
  endtask : rchk
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0a1c));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rchk(ADDR_STATUS_A);
    i_host.wreg(ADDR_FIFO_CFG, 8'h00);
    i_host.idle(3);
    // Low mark true out of reset: fill 0 against mark 0
    sa = 8'h20;
    rchk(ADDR_STATUS_A);
    i_host.wreg(ADDR_STATUS_A, 8'hFF);
    sa = 8'h7F;
    rchk(ADDR_STATUS_A);
    i_host.wreg(ADDR_STATUS_B, 8'hFF);
    sb = 8'h3F;
    rchk(ADDR_STATUS_B);
    // One event at a time from cleared flags
    for (int e = 0; e < 14; e++)
    begin
      i_host.wreg(ADDR_STATUS_A, 8'h7F);
      i_host.wreg(ADDR_STATUS_B, 8'h3F);
      i_host.idle(1);
      ev <= 14'h0001 << e;
      @(posedge mclk);
      ev <= 14'h0000;
      sa = e == 0 ? 8'h08 : e == 1 ? 8'h04 : e == 2 ? 8'h01 : e > 8 ? 8'h02 : 0;
      sb = e == 3 ? 8'h20 : (e > 3 && e < 9) ? 1 << (e - 4) : 0;
      rchk(ADDR_STATUS_A);
      rchk(ADDR_STATUS_B);
    end
    // Clear and set in the same cycle
    ev[0] <= 1'b1;
    i_host.wreg(ADDR_STATUS_A, 8'h08);
    ev[0] <= 1'b0;
    sa = 8'h0A;
    rchk(ADDR_STATUS_A);
    i_host.wreg(ADDR_COMMAND, 8'h01);
    i_host.idle(2);
    fin <= 1'b1;
    @(posedge mclk);
    fin <= 1'b0;
    sa = sa | 8'h10;
    @(posedge mclk);
    chk("command", CMD_IDLE, command_q);
    rchk(ADDR_STATUS_A);
    i_host.wreg(ADDR_STATUS_A, 8'h10);
    i_host.wreg(ADDR_COMMAND, 8'h02);
    i_host.wreg(ADDR_COMMAND, CMD_IDLE);
    sa = sa & 8'hEF;
    rchk(ADDR_STATUS_A);
    i_host.wreg(ADDR_COMMAND, 8'h0C);
    i_host.idle(3);
    sa = sa | 8'h10;
    chk("command", CMD_IDLE, command_q);
    rchk(ADDR_STATUS_A);
    // Watermark crossings, flags kept after levels drop
    i_host.wreg(ADDR_WATER, 8'h04);
    i_host.idle(1);
    fill <= 10'h064;
    i_host.wreg(ADDR_STATUS_A, 8'h60);
    i_host.idle(3);
    fill <= 10'h004;
    i_host.idle(3);
    fill <= 10'h1FC;
    i_host.idle(3);
    fill <= 10'h0C8;
    sa = sa | 8'h60;
    rchk(ADDR_STATUS_A);
    // Small capacity: high mark at a fill of 255 minus the watermark
    i_host.wreg(ADDR_FIFO_CFG, 8'h80);
    i_host.wreg(ADDR_STATUS_A, 8'h60);
    i_host.idle(1);
    fill <= 10'h0FB;
    i_host.idle(3);
    fill <= 10'h064;
    sa = (sa & 8'h9F) | 8'h40;
    rchk(ADDR_STATUS_A);
    // Random flags and enables, global and pin
    for (int i = 0; i < 12; i++)
    begin
      got = 8'($urandom);
      i_host.wreg(ADDR_STATUS_A, got);
      sa = got[7] ? sa | got[6:0] : sa & ~got[6:0];
      got = 8'($urandom);
      i_host.wreg(ADDR_STATUS_B, got);
      sb = got[7] ? sb | got[5:0] : sb & ~got[5:0];
      ena = $urandom & 8'hFF;
      enb = $urandom & 8'hFF;
      i_host.wreg(ADDR_ENABLE_A, 8'(ena));
      i_host.wreg(ADDR_ENABLE_B, 8'(enb));
      i_host.idle(3);
      v = (glob() && enb[6]) ^ ena[7];
      chk("pin", {7'h00, enb[7] && v}, {7'h00, pin_o});
      chk("oe", {7'h00, enb[7] || !v}, {7'h00, pin_oe});
      rchk(ADDR_STATUS_A);
      rchk(ADDR_STATUS_B);
      rchk(ADDR_ENABLE_A);
    end
    // Reset in mid-run: flags, enables and global back to zero
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    {sa, sb, ena, enb} = '0;
    rchk(ADDR_STATUS_A);
    rchk(ADDR_STATUS_B);
    rchk(8'h20);
    final_report();
  end
endmodule : tb_irq_unit
bind irq_unit irq_unit_check i_irq_unit_check (.mclk, .resetn, .addr,
  .wdata, .wr, .rd, .rdata_q, .cmd_finished, .tx_last_bit, .rx_stream_end,
  .card_found, .command_q, .irq_pin_o_q, .irq_pin_oe_q);
